// *** rtl/dpm_defs.svh ***
// timing counts and figures for the power-mode command tracker
// assumes a 40 MHz system clock; figures are in ns or us as printed
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

`define DPM_CLK_MHZ        40
`define DPM_CLK_NS         25
// least times round up to whole clocks
`define DPM_CYC_MIN(ns)    (((ns) + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_T_RFC_NS       80
`define DPM_T_MRD_NS       10
`define DPM_T_RAS_NS       40
`define DPM_T_XSR_NS       120
`define DPM_T_DPD_US       100
`define DPM_T_DPD_EXIT_US  200
`define DPM_RFC_CYC        14'(`DPM_CYC_MIN(`DPM_T_RFC_NS))
`define DPM_MRD_CYC        14'(`DPM_CYC_MIN(`DPM_T_MRD_NS))
`define DPM_RAS_CYC        4'(`DPM_CYC_MIN(`DPM_T_RAS_NS))
`define DPM_XSR_CYC        14'(`DPM_CYC_MIN(`DPM_T_XSR_NS))
`define DPM_DPD_CYC        14'(`DPM_T_DPD_US * `DPM_CLK_MHZ)
`define DPM_DPD_EXIT_CYC   (`DPM_T_DPD_EXIT_US * `DPM_CLK_MHZ)
// half the burst length (burst of four)
`define DPM_BURST_CYC      4'h2
`define DPM_BANKS          4
// bank address of the extended mode register
`define DPM_BA_EXT         2'h2

`endif

// *** rtl/dpm_pkg.sv ***
// types shared by the power-mode command tracker
// no assumptions beyond the defs header for widths
package dpm_pkg;

    // nine commands need a fourth bit
    typedef enum logic [3:0] {
        DPM_DESEL, DPM_NOP, DPM_ACT, DPM_RD, DPM_WR, DPM_PRE, DPM_BST, DPM_AREF, DPM_LMR
    } dpm_cmd_t;

    typedef enum logic [3:0] {
        DPM_RUN, DPM_REFRESH, DPM_MRD, DPM_PD_PRE, DPM_PD_ACT, DPM_SELF, DPM_DPD, DPM_WAIT
    } dpm_state_t;

    // command pins sampled on each rising clock edge
    typedef struct packed {
        logic       cke;
        logic       cs_n;
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic [1:0] ba;
        logic       a10;
    } dpm_pins_t;

    typedef struct packed {
        dpm_state_t      st;
        logic            cke_prev;
        logic [3:0]      open;
        logic [3:0][3:0] ras_cnt;
        logic            rd_act;
        logic            wr_act;
        logic [3:0]      burst_cnt;
        logic [13:0]     tmr;
        logic            reinit;
        logic            mr_seen;
        logic            err;
        logic            dq_oe_n;
        logic            dm_ignore;
    } dpm_regs_t;

endpackage

// *** rtl/dpm_core.sv ***
// command-legality and power-state tracker of a four-bank low-power ddr memory
// assumes command pins synchronous to clk_sys; the controller drives them
// Behaviour
// - burst terminate ends only the read burst in progress, whatever bank given
// - cke fall: idle or precharge gives precharge power-down, open row active
// - during refresh, mask ignored and data lines released
// - burst terminate with cke falling enters deep power-down
// - cke high leaves deep power-down
// - mode load busy until its delay ends, then every bank idle
`timescale 1ns/100ps
`include "dpm_defs.svh"

module dpm_core #(
    parameter int T_DPD_EXIT = `DPM_DPD_EXIT_CYC
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire dpm_pkg::dpm_pins_t  pins,
    output dpm_pkg::dpm_state_t      mode,
    output logic [3:0]               bank_open,
    output logic                     dq_oe_n,
    output logic                     dm_ignore,
    output logic                     cmd_err,
    output logic                     reinit_pending
);

    logic [1:0]         rst_sync_reg;
    dpm_pkg::dpm_regs_t state_reg;
    dpm_pkg::dpm_regs_t state_next;
    dpm_pkg::dpm_cmd_t  cmd;
    logic               rst_ok;

    // decode of the four command strobes
    function automatic dpm_pkg::dpm_cmd_t dpm_decode(input dpm_pkg::dpm_pins_t p);
        dpm_pkg::dpm_cmd_t c;
        c = dpm_pkg::DPM_DESEL;
        if (!p.cs_n) begin
            unique case ({p.ras_n, p.cas_n, p.we_n})
                3'h0: c = dpm_pkg::DPM_LMR;
                3'h1: c = dpm_pkg::DPM_AREF;
                3'h2: c = dpm_pkg::DPM_PRE;
                3'h3: c = dpm_pkg::DPM_ACT;
                3'h4: c = dpm_pkg::DPM_WR;
                3'h5: c = dpm_pkg::DPM_RD;
                3'h6: c = dpm_pkg::DPM_BST;
                3'h7: c = dpm_pkg::DPM_NOP;
            endcase
        end
        return c;
    endfunction

    // reset release through two flops; assertion is immediate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_ok = rst_sync_reg[1];

    assign cmd = dpm_decode(pins);

    // next-state logic of the whole tracker
    always_comb begin
        logic quiet;
        logic busy;
        quiet = (cmd == dpm_pkg::DPM_NOP) || (cmd == dpm_pkg::DPM_DESEL);
        busy  = state_reg.rd_act || state_reg.wr_act;
        state_next          = state_reg;
        state_next.err      = 1'b0;
        state_next.cke_prev = pins.cke;
        // row active timers run down in every state
        for (int b = 0; b < `DPM_BANKS; b++) begin
            if (state_reg.ras_cnt[b] != 4'h0) begin
                state_next.ras_cnt[b] = state_reg.ras_cnt[b] - 4'h1;
            end
        end
        // the data burst runs down on its own
        if (busy) begin
            state_next.burst_cnt = state_reg.burst_cnt - 4'h1;
            if (state_reg.burst_cnt == 4'h1) begin
                state_next.rd_act = 1'b0;
                state_next.wr_act = 1'b0;
            end
        end
        if (state_reg.tmr != 14'h0) begin
            state_next.tmr = state_reg.tmr - 14'h1;
        end
        unique case (state_reg.st)
            dpm_pkg::DPM_RUN: begin
                if (state_reg.cke_prev && !pins.cke) begin
                    if (cmd == dpm_pkg::DPM_BST) begin
                        // terminate under cke low means deep power-down
                        state_next.st     = dpm_pkg::DPM_DPD;
                        state_next.tmr    = `DPM_DPD_CYC;
                        state_next.open   = 4'h0;
                        state_next.reinit = 1'b1;
                        // a base mode load from before entry must not count
                        state_next.mr_seen = 1'b0;
                        state_next.rd_act = 1'b0;
                        state_next.wr_act = 1'b0;
                    end else if (cmd == dpm_pkg::DPM_AREF) begin
                        state_next.err = (state_reg.open != 4'h0) || busy;
                        state_next.st  = dpm_pkg::DPM_SELF;
                    end else begin
                        state_next.err = busy;
                        if (cmd == dpm_pkg::DPM_PRE) begin
                            state_next.open = pins.a10 ? 4'h0 :
                                (state_reg.open & ~(4'h1 << pins.ba));
                        end
                        if (cmd == dpm_pkg::DPM_ACT) begin
                            state_next.open[pins.ba] = 1'b1;
                        end
                        // mode chosen by rows left open after this edge
                        state_next.st = (state_next.open != 4'h0) ?
                            dpm_pkg::DPM_PD_ACT : dpm_pkg::DPM_PD_PRE;
                    end
                end else if (pins.cke) begin
                    unique case (cmd)
                        dpm_pkg::DPM_ACT: begin
                            state_next.open[pins.ba]    = 1'b1;
                            // loaded one short: a precharge on the edge tRAS ends is legal
                            state_next.ras_cnt[pins.ba] = `DPM_RAS_CYC - 4'h1;
                        end
                        dpm_pkg::DPM_PRE: begin
                            if (pins.a10) begin
                                state_next.err  = (state_reg.ras_cnt != '0);
                                state_next.open = 4'h0;
                            end else begin
                                state_next.err = (state_reg.ras_cnt[pins.ba] != 4'h0);
                                state_next.open[pins.ba] = 1'b0;
                            end
                        end
                        dpm_pkg::DPM_RD: begin
                            state_next.err       = !state_reg.open[pins.ba];
                            state_next.rd_act    = 1'b1;
                            state_next.wr_act    = 1'b0;
                            state_next.burst_cnt = `DPM_BURST_CYC;
                        end
                        dpm_pkg::DPM_WR: begin
                            // a read still running must be terminated first
                            state_next.err       = !state_reg.open[pins.ba] ||
                                                   state_reg.rd_act;
                            state_next.wr_act    = 1'b1;
                            state_next.rd_act    = 1'b0;
                            state_next.burst_cnt = `DPM_BURST_CYC;
                        end
                        dpm_pkg::DPM_BST: begin
                            // bank bits ignored: only the live read stops
                            state_next.rd_act = 1'b0;
                        end
                        dpm_pkg::DPM_AREF: begin
                            state_next.err = (state_reg.open != 4'h0) || busy;
                            state_next.st  = dpm_pkg::DPM_REFRESH;
                            state_next.tmr = `DPM_RFC_CYC;
                            if (state_reg.reinit && state_reg.mr_seen) begin
                                state_next.mr_seen = 1'b0;
                            end
                        end
                        dpm_pkg::DPM_LMR: begin
                            state_next.err = (state_reg.open != 4'h0) || busy;
                            state_next.st  = dpm_pkg::DPM_MRD;
                            state_next.tmr = `DPM_MRD_CYC;
                            // base mode first, then extended closes re-init
                            if (pins.ba != `DPM_BA_EXT) begin
                                state_next.mr_seen = 1'b1;
                            end else if (state_reg.mr_seen) begin
                                state_next.reinit  = 1'b0;
                                state_next.mr_seen = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            dpm_pkg::DPM_REFRESH, dpm_pkg::DPM_MRD: begin
                // nothing but nop or deselect until the busy time ends
                state_next.err = !quiet ||
                    (state_reg.st == dpm_pkg::DPM_REFRESH && !pins.cke);
                if (state_reg.tmr <= 14'h1) begin
                    state_next.st   = dpm_pkg::DPM_RUN;
                    state_next.open = 4'h0;
                end
            end
            dpm_pkg::DPM_PD_PRE, dpm_pkg::DPM_PD_ACT: begin
                if (pins.cke) begin
                    state_next.st = dpm_pkg::DPM_RUN;
                end
            end
            dpm_pkg::DPM_SELF: begin
                if (pins.cke) begin
                    state_next.st  = dpm_pkg::DPM_WAIT;
                    state_next.tmr = (`DPM_XSR_CYC < 14'h2) ? 14'h2 : `DPM_XSR_CYC;
                end
            end
            dpm_pkg::DPM_DPD: begin
                if (pins.cke) begin
                    // leaving early is flagged but still honoured
                    state_next.err = (state_reg.tmr > 14'h1);
                    state_next.st  = dpm_pkg::DPM_WAIT;
                    state_next.tmr = 14'(T_DPD_EXIT);
                end
            end
            dpm_pkg::DPM_WAIT: begin
                state_next.err = !quiet;
                if (state_reg.tmr <= 14'h1) begin
                    state_next.st = dpm_pkg::DPM_RUN;
                end
            end
            default: begin
                state_next.st = dpm_pkg::DPM_RUN;
            end
        endcase
        // read data driven only in run; refresh keeps the bus released
        state_next.dq_oe_n   = !(state_next.rd_act && state_next.st == dpm_pkg::DPM_RUN);
        state_next.dm_ignore = !(state_next.wr_act && state_next.st == dpm_pkg::DPM_RUN);
    end

    // one register for all state
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            state_reg           <= '0;
            state_reg.st        <= dpm_pkg::DPM_RUN;
            state_reg.dq_oe_n   <= 1'b1;
            state_reg.dm_ignore <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mode           = state_reg.st;
    assign bank_open      = state_reg.open;
    assign dq_oe_n        = state_reg.dq_oe_n;
    assign dm_ignore      = state_reg.dm_ignore;
    assign cmd_err        = state_reg.err;
    assign reinit_pending = state_reg.reinit;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_ok);

    chk_pd_kind: assert property (
        state_reg.st == dpm_pkg::DPM_PD_ACT && $past(state_reg.st) == dpm_pkg::DPM_RUN
        |-> state_reg.open != 4'h0) else $error("active power-down with no open row");
    chk_dpd_entry: assert property (
        state_reg.st == dpm_pkg::DPM_RUN && state_reg.cke_prev && !pins.cke
        && cmd == dpm_pkg::DPM_BST |=> state_reg.st == dpm_pkg::DPM_DPD && state_reg.reinit)
        else $error("deep power-down not entered");
    chk_dpd_exit: assert property (
        state_reg.st == dpm_pkg::DPM_DPD && pins.cke |=> state_reg.st == dpm_pkg::DPM_WAIT)
        else $error("deep power-down not left on cke high");
    chk_bst_scope: assert property (
        state_reg.st == dpm_pkg::DPM_RUN && pins.cke && cmd == dpm_pkg::DPM_BST
        && !state_reg.cke_prev == 1'b0 |=> !state_reg.rd_act)
        else $error("terminate left read burst running");
    chk_quiet_bus: assert property (
        state_reg.st == dpm_pkg::DPM_REFRESH |-> state_reg.dq_oe_n && state_reg.dm_ignore)
        else $error("bus not released during refresh");
    chk_mrd_idle: assert property (
        state_reg.st == dpm_pkg::DPM_MRD ##1 state_reg.st == dpm_pkg::DPM_RUN
        |-> state_reg.open == 4'h0) else $error("banks not idle after mode load");
    chk_ref_hold: assert property (
        state_reg.st == dpm_pkg::DPM_RUN && pins.cke && state_reg.cke_prev
        && cmd == dpm_pkg::DPM_AREF |=> (state_reg.st == dpm_pkg::DPM_REFRESH)[*3])
        else $error("refresh busy time cut short");
    chk_read_drive: assert property (
        $rose(state_reg.rd_act) |-> !state_reg.dq_oe_n ##[1:4] state_reg.dq_oe_n)
        else $error("read drive did not end with burst");

endmodule

// *** tb/dpm_ctrl_model.sv ***
// controller-side model: turns one command request into pin levels
// assumes requests change just after the rising edge of clk_sys
`timescale 1ns/100ps

module dpm_ctrl_model (
    input  wire logic               clk_sys,
    input  wire dpm_pkg::dpm_cmd_t  cmd,
    input  wire logic               cke,
    input  wire logic [1:0]         ba,
    input  wire logic               a10,
    output dpm_pkg::dpm_pins_t      pins
);
    logic flip_reg = 1'b0;

    // unselected command lines wander so a deselect never replays a stale command
    always_ff @(posedge clk_sys) begin
        flip_reg <= ~flip_reg;
    end

    // encoding; the clock never stops, so exits always see running clocks
    always_comb begin
        pins = '{cke: cke, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: ba, a10: a10};
        case (cmd)
            dpm_pkg::DPM_ACT:  {pins.ras_n, pins.cas_n, pins.we_n} = 3'h3;
            dpm_pkg::DPM_RD:   {pins.ras_n, pins.cas_n, pins.we_n} = 3'h5;
            dpm_pkg::DPM_WR:   {pins.ras_n, pins.cas_n, pins.we_n} = 3'h4;
            dpm_pkg::DPM_PRE:  {pins.ras_n, pins.cas_n, pins.we_n} = 3'h2;
            dpm_pkg::DPM_BST:  {pins.ras_n, pins.cas_n, pins.we_n} = 3'h6;
            dpm_pkg::DPM_AREF: {pins.ras_n, pins.cas_n, pins.we_n} = 3'h1;
            dpm_pkg::DPM_LMR:  {pins.ras_n, pins.cas_n, pins.we_n} = 3'h0;
            dpm_pkg::DPM_DESEL: begin
                pins.cs_n = 1'b1;
                {pins.ras_n, pins.cas_n, pins.we_n} = {3{flip_reg}};
            end
            default: ;
        endcase
    end
endmodule

// *** tb/ddr_power_mode_command_rules_tb.sv ***
// self-checking bench of the power-mode command tracker
// assumes dpm_core and the controller model; exit wait shortened to 20 cycles
`timescale 1ns/100ps

module ddr_power_mode_command_rules_tb;
    localparam int EXIT_CYC = 20;
    logic                clk_sys = 1'b0;
    logic                rst_n   = 1'b0;
    dpm_pkg::dpm_cmd_t   req_cmd = dpm_pkg::DPM_NOP;
    logic                req_cke = 1'b1;
    logic [1:0]          req_ba  = 2'h0;
    logic                req_a10 = 1'b0;
    logic                cke_q   = 1'b1;
    dpm_pkg::dpm_pins_t  pins;
    dpm_pkg::dpm_state_t mode;
    logic [3:0]          bank_open;
    logic                dq_oe_n;
    logic                dm_ignore;
    logic                cmd_err;
    logic                reinit_pending;
    int                  fails = 0;
    int                  comparisons = 0;
    int                  n;
    logic [1:0]          b;

    always #12.5 clk_sys = ~clk_sys;

    dpm_ctrl_model u_ctrl (.clk_sys(clk_sys), .cmd(req_cmd), .cke(req_cke), .ba(req_ba),
                           .a10(req_a10), .pins(pins));

    dpm_core #(.T_DPD_EXIT(EXIT_CYC)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
        .mode(mode), .bank_open(bank_open), .dq_oe_n(dq_oe_n), .dm_ignore(dm_ignore),
        .cmd_err(cmd_err), .reinit_pending(reinit_pending));

    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // one command per cycle; after it returns, outputs show the previous command
    task automatic step(input dpm_pkg::dpm_cmd_t c, input logic [1:0] bk = 2'h0,
                        input logic a = 1'b0);
        @(posedge clk_sys);
        req_cmd <= c;
        req_ba  <= bk;
        req_a10 <= a;
        req_cke <= cke_q;
        #1;
    endtask

    // cycles the tracker stays in state s, counted from its first visible cycle
    task automatic dwell(input dpm_pkg::dpm_state_t s, output int cnt);
        cnt = 0;
        while (mode === s && cnt < 60) begin
            step(dpm_pkg::DPM_NOP);
            cnt++;
        end
    endtask

    function automatic dpm_pkg::dpm_state_t pd_kind(input logic row_open);
        return row_open ? dpm_pkg::DPM_PD_ACT : dpm_pkg::DPM_PD_PRE;
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog sized well beyond the longest sequence (deep power-down hold)
    initial begin
        #(25 * 20000);
        fails++;
        end_of_test();
    end

    initial begin
        n = $urandom(32'h990aa0b5);
        repeat (2) @(posedge clk_sys);
        check(mode, dpm_pkg::DPM_RUN, "reset mode");
        check({bank_open, dq_oe_n, dm_ignore, cmd_err, reinit_pending}, 8'h0C, "reset outs");
        rst_n <= 1'b1;
        repeat (3) step(dpm_pkg::DPM_NOP);
        // random banks and row-active spans, deselects as filler
        for (int i = 0; i < 16; i++) begin
            b = 2'($urandom_range(3));
            step(dpm_pkg::DPM_ACT, b);
            step(dpm_pkg::DPM_DESEL);
            check(bank_open, 8'(4'h1 << b), "row open");
            repeat ($urandom_range(2)) step(dpm_pkg::DPM_DESEL);
            step(dpm_pkg::DPM_PRE, b);
            step(dpm_pkg::DPM_NOP);
            check(cmd_err, 1'b0, "legal precharge");
            check(bank_open, 8'h00, "row closed");
        end
        step(dpm_pkg::DPM_ACT, 2'h1);
        step(dpm_pkg::DPM_PRE, 2'h1);
        step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "early precharge");
        // terminate given bank 0, the bank of the running read, ends that read
        step(dpm_pkg::DPM_ACT, 2'h0);
        repeat (2) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_RD, 2'h0);
        step(dpm_pkg::DPM_BST, 2'h0);
        check(dq_oe_n, 1'b0, "read drives");
        step(dpm_pkg::DPM_NOP);
        check(dq_oe_n, 1'b1, "burst ended");
        check(cmd_err, 1'b0, "terminate legal");
        step(dpm_pkg::DPM_RD, 2'h0);
        step(dpm_pkg::DPM_WR, 2'h0);
        step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "write in read");
        check(dm_ignore, 1'b0, "mask live in write");
        repeat (3) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_RD, 2'h0);
        cke_q = 1'b0;
        repeat (2) step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "pd in burst");
        cke_q = 1'b1;
        repeat (3) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_AREF);
        step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "refresh open row");
        repeat (6) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_PRE, 2'h0, 1'b1);
        step(dpm_pkg::DPM_NOP);
        check(bank_open, 8'h00, "precharge all");
        // both power-down kinds, each exited after one running clock
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                step(dpm_pkg::DPM_ACT, 2'h3);
                step(dpm_pkg::DPM_NOP);
            end
            cke_q = 1'b0;
            repeat (2) step(dpm_pkg::DPM_NOP);
            check(mode, pd_kind(k[0]), "pd kind");
            cke_q = 1'b1;
            repeat (2) step(dpm_pkg::DPM_NOP);
            check(mode, dpm_pkg::DPM_RUN, "pd exit");
        end
        step(dpm_pkg::DPM_PRE, 2'h3);
        step(dpm_pkg::DPM_AREF);
        step(dpm_pkg::DPM_NOP);
        check(mode, dpm_pkg::DPM_REFRESH, "refresh");
        check({dq_oe_n, dm_ignore}, 8'h03, "lines released");
        dwell(dpm_pkg::DPM_REFRESH, n);
        check(n, 8'd4, "refresh span");
        step(dpm_pkg::DPM_AREF);
        step(dpm_pkg::DPM_ACT, 2'h1);
        step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "cmd in refresh");
        repeat (5) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_PRE, 2'h0, 1'b1);
        step(dpm_pkg::DPM_AREF);
        cke_q = 1'b0;
        repeat (2) step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "cke low refresh");
        cke_q = 1'b1;
        repeat (12) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_PRE, 2'h0, 1'b1);
        step(dpm_pkg::DPM_LMR);
        step(dpm_pkg::DPM_NOP);
        check(mode, dpm_pkg::DPM_MRD, "mode load");
        dwell(dpm_pkg::DPM_MRD, n);
        check(n, 8'd1, "mode delay");
        check(bank_open, 8'h00, "idle after load");
        step(dpm_pkg::DPM_ACT, 2'h2);
        step(dpm_pkg::DPM_NOP);
        cke_q = 1'b0;
        step(dpm_pkg::DPM_AREF);
        step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "self ref open");
        cke_q = 1'b1;
        repeat (10) step(dpm_pkg::DPM_NOP);
        step(dpm_pkg::DPM_PRE, 2'h0, 1'b1);
        cke_q = 1'b0;
        step(dpm_pkg::DPM_AREF);
        step(dpm_pkg::DPM_NOP);
        check(mode, dpm_pkg::DPM_SELF, "self refresh");
        repeat (3) step(dpm_pkg::DPM_NOP);
        cke_q = 1'b1;
        repeat (2) step(dpm_pkg::DPM_NOP);
        dwell(dpm_pkg::DPM_WAIT, n);
        check(n, 8'd5, "self exit wait");
        // deep power-down, full hold, exit wait and the re-initialisation order
        cke_q = 1'b0;
        step(dpm_pkg::DPM_BST);
        step(dpm_pkg::DPM_NOP);
        check(mode, dpm_pkg::DPM_DPD, "deep pd");
        check(reinit_pending, 1'b1, "contents lost");
        repeat (4000) step(dpm_pkg::DPM_NOP);
        cke_q = 1'b1;
        repeat (2) step(dpm_pkg::DPM_NOP);
        check(mode, dpm_pkg::DPM_WAIT, "deep pd exit");
        dwell(dpm_pkg::DPM_WAIT, n);
        check(n, 8'(EXIT_CYC), "exit wait");
        step(dpm_pkg::DPM_PRE, 2'h0, 1'b1);
        repeat (2) begin
            step(dpm_pkg::DPM_AREF);
            repeat (5) step(dpm_pkg::DPM_NOP);
        end
        step(dpm_pkg::DPM_LMR, 2'h0);
        step(dpm_pkg::DPM_NOP);
        check(reinit_pending, 1'b1, "base mode only");
        step(dpm_pkg::DPM_LMR, 2'h2);
        step(dpm_pkg::DPM_NOP);
        check({reinit_pending, cmd_err}, 8'h00, "reinit done");
        cke_q = 1'b0;
        step(dpm_pkg::DPM_BST);
        cke_q = 1'b1;
        repeat (2) step(dpm_pkg::DPM_NOP);
        check(cmd_err, 1'b1, "early deep exit");
        repeat (40) step(dpm_pkg::DPM_NOP);
        end_of_test();
    end
endmodule
